// file: rtl/dac_mode_map.vh
// Register indices, field positions, reset values and counts of the mode bank
`ifndef DAC_MODE_MAP_VH
`define DAC_MODE_MAP_VH
`define IDX_LEFT_ATTEN 7'h10
`define IDX_RIGHT_ATTEN 7'h11
`define IDX_MUTE_OVS 7'h12
`define IDX_DAC_DEEMPH 7'h13
`define IDX_FMT_FILT 7'h14
`define IDX_PHASE_ZERO 7'h16
`define ATTEN_RESET 8'hFF
`define CTRL_RESET 8'h00
`define ATTEN_MUTE_MAX 8'h80
`define WORD_BITS 5'h10
`define BIT_MUTE_L 0
`define BIT_MUTE_R 1
`define BIT_OVS 6
`define BIT_DIS_L 0
`define BIT_DIS_R 1
`define BIT_DEEMPH_EN 4
`define BIT_DEEMPH_LO 5
`define BIT_DEEMPH_HI 6
`define BIT_FMT_LO 0
`define BIT_FMT_HI 2
`define BIT_ROLLOFF 5
`define BIT_INVERT 0
`define BIT_ZERO_FLAG_ACTIVE_LOW 1
`define BIT_ZCOMMON 2
`define DEEMPH_RSVD 2'h3
`define FMT_MAX 3'h5
`define ZERO_SAMPLES 1024
`endif

// file: rtl/pin_sync3.v
// Three-stage pin synchroniser with agreement-qualified output
`timescale 1ns/1ps
module pin_sync3 #(
    parameter WIDTH = 3
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] pin_out
);
    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;
    integer i;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= {WIDTH{1'b0}};
            s2_r <= {WIDTH{1'b0}};
            s3_r <= {WIDTH{1'b0}};
            pin_out <= {WIDTH{1'b0}};
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Only a settled level is passed on
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    pin_out[i] <= s3_r[i];
                end
            end
        end
    end
endmodule // pin_sync3

// file: rtl/dac_mode_regs.v
// Mode control register bank with serial control port, soft mute and zero flags
`timescale 1ns/1ps
`include "dac_mode_map.vh"
module dac_mode_regs #(
    parameter ZERO_COUNT = `ZERO_SAMPLES
) (
    input wire clk_sys,
    input wire rst_n,
    input wire ctrl_latch,
    input wire ctrl_clock,
    input wire ctrl_serial_in,
    input wire word_clock,
    input wire left_data_zero,
    input wire right_data_zero,
    output reg [7:0] left_atten_code,
    output reg [7:0] right_atten_code,
    output reg left_muted,
    output reg right_muted,
    output reg oversample_128,
    output reg left_chan_disable,
    output reg right_chan_disable,
    output reg deemph_en,
    output reg [1:0] deemph_rate_sel,
    output reg [2:0] audio_format_sel,
    output reg rolloff_slow_sel,
    output reg output_invert,
    output reg right_zero_flag,
    output reg left_zero_flag
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire [3:0] pins_s;
    pin_sync3 #(.WIDTH(4)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in({word_clock, ctrl_serial_in, ctrl_clock, ctrl_latch}),
        .pin_out(pins_s)
    );
    wire latch_s = pins_s[0];
    wire mclk_s = pins_s[1];
    wire mdat_s = pins_s[2];
    wire wclk_s = pins_s[3];

    reg latch_d_r;
    reg mclk_d_r;
    reg wclk_d_r;
    wire mclk_rise = mclk_s & ~mclk_d_r;
    wire latch_rise = latch_s & ~latch_d_r;
    wire latch_fall = ~latch_s & latch_d_r;
    wire sample_edge = wclk_s & ~wclk_d_r;

    // ------------------------------------------------------------
    // Serial control port
    // ------------------------------------------------------------
    reg [15:0] shift_r;
    reg [4:0] bit_cnt_r;
    reg in_frame_r;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // Matches the synchroniser's reset level; an idle-high latch still gives one rising edge after reset, with no frame open
            latch_d_r <= 1'b0;
            mclk_d_r <= 1'b0;
            wclk_d_r <= 1'b0;
            shift_r <= 16'h0000;
            bit_cnt_r <= 5'h00;
            in_frame_r <= 1'b0;
        end else begin
            latch_d_r <= latch_s;
            mclk_d_r <= mclk_s;
            wclk_d_r <= wclk_s;
            if (latch_fall) begin
                in_frame_r <= 1'b1;
                bit_cnt_r <= 5'h00;
            end else if (latch_rise) begin
                in_frame_r <= 1'b0;
            end else if (in_frame_r && mclk_rise && bit_cnt_r != `WORD_BITS) begin
                shift_r <= {shift_r[14:0], mdat_s};
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end
    end

    // Commit only complete words with a zero top bit
    wire commit = latch_rise && in_frame_r && bit_cnt_r == `WORD_BITS
        && !shift_r[15];
    wire [6:0] reg_index = shift_r[14:8];
    wire [7:0] wdata = shift_r[7:0];

    // ------------------------------------------------------------
    // Mode registers
    // ------------------------------------------------------------
    reg [7:0] atten_l_r;
    reg [7:0] atten_r_r;
    reg [1:0] soft_mute_en_r;
    reg [1:0] chan_disable_r;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            atten_l_r <= `ATTEN_RESET;
            atten_r_r <= `ATTEN_RESET;
            soft_mute_en_r <= 2'h0;
            oversample_128 <= 1'b0;
            chan_disable_r <= 2'h0;
            left_chan_disable <= 1'b0;
            right_chan_disable <= 1'b0;
            deemph_en <= 1'b0;
            deemph_rate_sel <= 2'h0;
            audio_format_sel <= 3'h0;
            rolloff_slow_sel <= 1'b0;
            output_invert <= 1'b0;
        end else begin
            left_chan_disable <= chan_disable_r[0];
            right_chan_disable <= chan_disable_r[1];
            if (commit) begin
                case (reg_index)
                    `IDX_LEFT_ATTEN: begin
                        atten_l_r <= wdata;
                    end
                    `IDX_RIGHT_ATTEN: begin
                        atten_r_r <= wdata;
                    end
                    `IDX_MUTE_OVS: begin
                        soft_mute_en_r <= {wdata[`BIT_MUTE_R], wdata[`BIT_MUTE_L]};
                        oversample_128 <= wdata[`BIT_OVS];
                    end
                    `IDX_DAC_DEEMPH: begin
                        chan_disable_r <= {wdata[`BIT_DIS_R], wdata[`BIT_DIS_L]};
                        deemph_en <= wdata[`BIT_DEEMPH_EN];
                        // Reserved rate code leaves the old rate in place
                        if (wdata[`BIT_DEEMPH_HI:`BIT_DEEMPH_LO] != `DEEMPH_RSVD) begin
                            deemph_rate_sel <= wdata[`BIT_DEEMPH_HI:`BIT_DEEMPH_LO];
                        end
                    end
                    `IDX_FMT_FILT: begin
                        if (wdata[`BIT_FMT_HI:`BIT_FMT_LO] <= `FMT_MAX) begin
                            audio_format_sel <= wdata[`BIT_FMT_HI:`BIT_FMT_LO];
                        end
                        rolloff_slow_sel <= wdata[`BIT_ROLLOFF];
                    end
                    `IDX_PHASE_ZERO: begin
                        output_invert <= wdata[`BIT_INVERT];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    reg zero_flag_active_low_r;
    reg zcommon_r;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            zero_flag_active_low_r <= 1'b0;
            zcommon_r <= 1'b0;
        end else if (commit && reg_index == `IDX_PHASE_ZERO) begin
            zero_flag_active_low_r <= wdata[`BIT_ZERO_FLAG_ACTIVE_LOW];
            zcommon_r <= wdata[`BIT_ZCOMMON];
        end
    end

    // ------------------------------------------------------------
    // Attenuators with soft mute
    // ------------------------------------------------------------
    // Codes at or below the mute boundary collapse to zero gain
    function [7:0] atten_step;
        input [7:0] cur;
        input [7:0] target;
        input mute;
        begin
            if (mute) begin
                atten_step = (cur > `ATTEN_MUTE_MAX) ? cur - 8'h01 : `ATTEN_MUTE_MAX;
            end else begin
                atten_step = target;
            end
        end
    endfunction

    function is_muted;
        input [7:0] code;
        begin
            is_muted = (code <= `ATTEN_MUTE_MAX);
        end
    endfunction

    // Applied code changes once per sample, one step down while muting until it holds at 8'h80, so the mute ramp is audio-rate
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            left_atten_code <= `ATTEN_RESET;
            right_atten_code <= `ATTEN_RESET;
            left_muted <= 1'b0;
            right_muted <= 1'b0;
        end else begin
            if (sample_edge) begin
                left_atten_code <= atten_step(left_atten_code, atten_l_r,
                    soft_mute_en_r[0]);
                right_atten_code <= atten_step(right_atten_code, atten_r_r,
                    soft_mute_en_r[1]);
            end
            left_muted <= is_muted(left_atten_code);
            right_muted <= is_muted(right_atten_code);
        end
    end

    // ------------------------------------------------------------
    // Zero detect
    // ------------------------------------------------------------
    reg [10:0] zcnt_l_r;
    reg [10:0] zcnt_r_r;
    wire zdet_l = (zcnt_l_r == ZERO_COUNT[10:0]);
    wire zdet_r = (zcnt_r_r == ZERO_COUNT[10:0]);

    function [10:0] zero_next;
        input [10:0] cnt;
        input zero;
        begin
            if (!zero) begin
                zero_next = 11'h000;
            end else if (cnt == ZERO_COUNT[10:0]) begin
                zero_next = cnt;
            end else begin
                zero_next = cnt + 11'h001;
            end
        end
    endfunction

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            zcnt_l_r <= 11'h000;
            zcnt_r_r <= 11'h000;
            left_zero_flag <= 1'b0;
            right_zero_flag <= 1'b0;
        end else begin
            if (sample_edge) begin
                zcnt_l_r <= zero_next(zcnt_l_r, left_data_zero);
                zcnt_r_r <= zero_next(zcnt_r_r, right_data_zero);
            end
            if (zcommon_r) begin
                right_zero_flag <= (zdet_l & zdet_r) ^ zero_flag_active_low_r;
                left_zero_flag <= 1'b0; // Unassigned pin rests low
            end else begin
                right_zero_flag <= zdet_r ^ zero_flag_active_low_r;
                left_zero_flag <= zdet_l ^ zero_flag_active_low_r;
            end
        end
    end
endmodule // dac_mode_regs

// file: dv/dac_mode_regs_checker.sv
// Concurrent checks on the ports of the mode control register bank
`timescale 1ns/1ps
module dac_mode_regs_checker #(
    parameter ZERO_COUNT = 1024
) (
    input wire clk_sys,
    input wire rst_n,
    input wire ctrl_latch,
    input wire word_clock,
    input wire [7:0] left_atten_code,
    input wire [7:0] right_atten_code,
    input wire left_muted,
    input wire right_muted,
    input wire oversample_128,
    input wire left_chan_disable,
    input wire right_chan_disable,
    input wire deemph_en,
    input wire [1:0] deemph_rate_sel,
    input wire [2:0] audio_format_sel,
    input wire rolloff_slow_sel,
    input wire output_invert,
    input wire right_zero_flag,
    input wire left_zero_flag
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_left_mute_flag: assert property (
        left_muted == ($past(left_atten_code) <= 8'h80)) else $error("left mute flag");
    a_right_mute_flag: assert property (
        right_muted == ($past(right_atten_code) <= 8'h80)) else $error("right mute flag");
    // Applied codes may only move on a sample boundary
    a_left_sample_step: assert property (
        $stable(word_clock) [*8] |=> $stable(left_atten_code)) else $error("left code moved");
    a_right_sample_step: assert property (
        $stable(word_clock) [*8] |=> $stable(right_atten_code)) else $error("right code moved");
    a_ctrl_only_commit: assert property (
        ctrl_latch [*8] |=> $stable({oversample_128, left_chan_disable, right_chan_disable,
        deemph_en, deemph_rate_sel, audio_format_sel, rolloff_slow_sel, output_invert}))
        else $error("control changed without commit");
    a_flags_quiet: assert property (
        (ctrl_latch && $stable(word_clock)) [*8] |=> $stable({left_zero_flag, right_zero_flag}))
        else $error("zero flag changed");
    a_rate_legal: assert property (deemph_rate_sel != 2'h3)
        else $error("reserved rate applied");
    a_format_legal: assert property (audio_format_sel <= 3'h5)
        else $error("reserved format applied");
endmodule // dac_mode_regs_checker

bind dac_mode_regs dac_mode_regs_checker #(.ZERO_COUNT(ZERO_COUNT)) u_checker (
    .clk_sys(clk_sys), .rst_n(rst_n), .ctrl_latch(ctrl_latch), .word_clock(word_clock),
    .left_atten_code(left_atten_code), .right_atten_code(right_atten_code),
    .left_muted(left_muted), .right_muted(right_muted), .oversample_128(oversample_128),
    .left_chan_disable(left_chan_disable), .right_chan_disable(right_chan_disable),
    .deemph_en(deemph_en), .deemph_rate_sel(deemph_rate_sel),
    .audio_format_sel(audio_format_sel), .rolloff_slow_sel(rolloff_slow_sel),
    .output_invert(output_invert), .right_zero_flag(right_zero_flag),
    .left_zero_flag(left_zero_flag));

// file: dv/host_ctrl_port_model.sv
// Host model driving the three-wire control port
`timescale 1ns/1ps
module host_ctrl_port_model (
    input wire clk_sys,
    output logic ctrl_latch = 1'b1,
    output logic ctrl_clock = 1'b0,
    output logic ctrl_serial_in = 1'b0
);
    // Each pin level lasts four system clocks, the fastest the port must accept
    task automatic hold;
        repeat (4) @(negedge clk_sys);
    endtask
    // Sends the top n bits of w; any n below 16 makes a frame to be dropped, clocks past 16 are ignored
    task automatic send(input [15:0] w, input [4:0] n);
        @(negedge clk_sys);
        ctrl_latch = 1'b0;
        for (int i = 0; i < n; i++) begin
            ctrl_serial_in = w[15 - i];
            hold();
            ctrl_clock = 1'b1;
            hold();
            ctrl_clock = 1'b0;
        end
        hold();
        ctrl_latch = 1'b1;
        ctrl_serial_in = ~ctrl_serial_in;
        hold();
    endtask
endmodule // host_ctrl_port_model

// file: dv/stereo_dac_mode_control_regs_bench.sv
// Self-checking bench for the mode control register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module stereo_dac_mode_control_regs_bench;
    logic clk_sys = 1'b0;
    logic rst_n, word_clock, left_data_zero, right_data_zero;
    wire ctrl_latch, ctrl_clock, ctrl_serial_in, left_muted, right_muted, oversample_128;
    wire left_chan_disable, right_chan_disable, deemph_en, rolloff_slow_sel, output_invert;
    wire right_zero_flag, left_zero_flag;
    wire [7:0] left_atten_code, right_atten_code;
    wire [1:0] deemph_rate_sel;
    wire [2:0] audio_format_sel;
    wire [15:0] atten_pair = {left_atten_code, right_atten_code};
    wire [4:0] dis_deemph = {left_chan_disable, right_chan_disable, deemph_en, deemph_rate_sel};
    wire [3:0] filt_fmt = {rolloff_slow_sel, audio_format_sel};
    wire [1:0] zero_flags = {left_zero_flag, right_zero_flag};
    int miscompares = 0;
    int num_checks = 0;
    always #10 clk_sys = ~clk_sys;
    host_ctrl_port_model host (.clk_sys(clk_sys), .ctrl_latch(ctrl_latch),
        .ctrl_clock(ctrl_clock), .ctrl_serial_in(ctrl_serial_in));
    // Short zero count keeps the detect scenarios brief
    dac_mode_regs #(.ZERO_COUNT(8)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .ctrl_latch(ctrl_latch), .ctrl_clock(ctrl_clock), .ctrl_serial_in(ctrl_serial_in),
        .word_clock(word_clock), .left_data_zero(left_data_zero),
        .right_data_zero(right_data_zero), .left_atten_code(left_atten_code),
        .right_atten_code(right_atten_code), .left_muted(left_muted), .right_muted(right_muted),
        .oversample_128(oversample_128), .left_chan_disable(left_chan_disable),
        .right_chan_disable(right_chan_disable), .deemph_en(deemph_en),
        .deemph_rate_sel(deemph_rate_sel), .audio_format_sel(audio_format_sel),
        .rolloff_slow_sel(rolloff_slow_sel), .output_invert(output_invert),
        .right_zero_flag(right_zero_flag), .left_zero_flag(left_zero_flag));
    task automatic wr(input [6:0] idx, input [7:0] data);
        host.send({1'h0, idx, data}, 5'h10);
        repeat (10) @(negedge clk_sys);
    endtask
    // Long low phase lets the synchronised sample edge settle
    task automatic wc(input int n);
        repeat (n) begin
            word_clock = 1'b1;
            repeat (4) @(negedge clk_sys);
            word_clock = 1'b0;
            repeat (8) @(negedge clk_sys);
        end
    endtask
    task automatic final_report;
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        word_clock = 1'b0;
        left_data_zero = 1'b0;
        right_data_zero = 1'b0;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        `CHK(atten_pair, 16'hFFFF)
        `CHK({dis_deemph, filt_fmt, zero_flags, oversample_128, output_invert}, 13'h0000)
        wr(7'h10, 8'h81);
        wr(7'h11, 8'h80);
        wc(1);
        `CHK(atten_pair, 16'h8180)
        `CHK({left_muted, right_muted}, 2'h1)
        wr(7'h12, 8'h41);
        wc(2);
        `CHK({left_atten_code, left_muted, oversample_128}, 10'h203)
        wr(7'h12, 8'h00);
        wr(7'h10, 8'hFE);
        wc(1);
        `CHK(left_atten_code, 8'hFE)
        wr(7'h12, 8'h01);
        wc(2);
        `CHK(left_atten_code, 8'hFC)
        wr(7'h12, 8'hBC);
        host.send({1'h1, 7'h10, 8'h00}, 5'h10);
        host.send({1'h0, 7'h11, 8'h00}, 5'h0F);
        wr(7'h15, 8'h00);
        wc(1);
        `CHK({atten_pair, oversample_128}, 17'h1FD00)
        wr(7'h13, 8'h33);
        `CHK(dis_deemph, 5'h1D)
        wr(7'h13, 8'h70);
        `CHK(dis_deemph, 5'h05)
        wr(7'h13, 8'h40);
        `CHK(dis_deemph, 5'h02)
        for (int i = 0; i < 6; i++) begin
            wr(7'h14, 8'h20 | 8'(i));
            `CHK(filt_fmt, 4'h8 | 4'(i))
        end
        wr(7'h14, 8'h07);
        `CHK(filt_fmt, 4'h5)
        left_data_zero = 1'b1;
        wc(7);
        `CHK(zero_flags, 2'h0)
        wc(1);
        `CHK(zero_flags, 2'h2)
        wr(7'h16, 8'h03);
        `CHK({zero_flags, output_invert}, 3'h3)
        wr(7'h16, 8'h04);
        `CHK(zero_flags, 2'h0)
        right_data_zero = 1'b1;
        wc(8);
        `CHK(zero_flags, 2'h1)
        final_report();
    end
endmodule // stereo_dac_mode_control_regs_bench
